// ===== pkg/dci_regs.svh
// Constants for the daisy-chain interrupt logic.
// Assumes inclusion by the package and the design file only.
`ifndef DCI_REGS_SVH
`define DCI_REGS_SVH

`define DCI_LEVELS 6
`define DCI_OP_PREFIX 8'hed
`define DCI_OP_RETURN 8'h4d
`define DCI_VEC_BASE 8'h00
`define DCI_VEC_LSB 1
`define DCI_LVL_W 3

`endif

// ===== pkg/dci_pkg.sv
// Types for the daisy-chain interrupt logic.
// Assumes dci_regs.svh is on the include path.
`include "dci_regs.svh"

package dci_pkg;
    typedef logic [`DCI_LEVELS-1:0] dci_lvl_t;
    typedef logic [7:0] dci_byte_t;

    // Processor bus strobes, all active low, plus the data bus value
    typedef struct packed {
        logic opcode_fetch_n;
        logic io_request_n;
        logic read_n;
        dci_byte_t data;
    } dci_bus_s;

    typedef enum logic [1:0] {
        DCI_IDLE,
        DCI_PREFIX_SEEN
    } dci_dec_e;
endpackage : dci_pkg

// ===== design/dci_daisy_chain.sv
// Daisy-chain interrupt logic for a two-channel serial controller.
// Assumes bus strobes and chain input arrive asynchronously from pins;
// source requests and the return command come from same-clock logic.
//
// Function
// - Drive interrupt request low while any level above every in-service one is pending.
// - No pending or in-service level: chain enable out follows in.
// - Pending or in-service level: chain enable out held low.
// - Interrupt status frozen while opcode fetch strobe is low.
// - Acknowledge with chain enable in high: drive vector, set in-service.
// - After prefix fetch, pending unacknowledged levels no longer block chain.
// - Return opcode after prefix clears in-service of chain-selected device.
// - Software return command clears the serviced in-service latch.
// - Six internal levels, fixed priority, channel A above channel B.
// - Higher level may nest over lower; lower resumes after clear.
`timescale 1ns/100ps
`include "dci_regs.svh"

module dci_daisy_chain (
    input wire logic mclk,
    input wire logic rst_b,
    input wire dci_pkg::dci_bus_s bus_pin,
    input wire logic chain_enable_in,
    input wire dci_pkg::dci_lvl_t source_req,
    input wire logic return_cmd,
    input wire logic [7:0] vector_base,
    output logic int_req_n,
    output logic chain_enable_out,
    output dci_pkg::dci_byte_t data_out,
    output logic data_oe,
    output dci_pkg::dci_lvl_t in_service
);
    import dci_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Bit 0 is the highest level (channel A receive)
    // Scans from the lowest level up, so the last hit, the highest, wins
    function automatic dci_lvl_t dci_top(input dci_lvl_t v);
        dci_lvl_t r;
        r = '0;
        for (int i = `DCI_LEVELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : dci_top

    // Mask of all levels below (lower priority than) the given one-hot level
    function automatic dci_lvl_t dci_below(input dci_lvl_t onehot);
        dci_lvl_t r;
        r = '0;
        for (int i = 1; i < `DCI_LEVELS; i++) begin
            r[i] = r[i-1] | onehot[i-1];
        end
        return r;
    endfunction : dci_below

    function automatic logic [`DCI_LVL_W-1:0] dci_index(input dci_lvl_t onehot);
        logic [`DCI_LVL_W-1:0] r;
        r = '0;
        for (int i = 0; i < `DCI_LEVELS; i++) begin
            if (onehot[i]) begin
                r = `DCI_LVL_W'(i);
            end
        end
        return r;
    endfunction : dci_index

    // Level index lands in the vector field; the base supplies the other bits
    function automatic dci_byte_t dci_vector(input dci_byte_t base, input dci_lvl_t onehot);
        dci_byte_t field;
        field = dci_byte_t'(dci_index(onehot));
        return base | (field << `DCI_VEC_LSB);
    endfunction : dci_vector

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    dci_bus_s bus_meta;
    dci_bus_s bus_sync;
    logic iei_meta;
    logic iei_sync;
    logic io_request_n_prev;
    logic fetch_prev;

    // Strobes reset to their idle level so no false edge follows reset.
    // Data is only read at a strobe edge, long after it has settled.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus_meta <= '{opcode_fetch_n: 1'b1, io_request_n: 1'b1, read_n: 1'b1, data: '0};
            bus_sync <= '{opcode_fetch_n: 1'b1, io_request_n: 1'b1, read_n: 1'b1, data: '0};
        end else begin
            bus_meta <= bus_pin;
            bus_sync <= bus_meta;
        end
    end

    // Chain input resets low: the output stays low until the pin is seen,
    // which keeps devices further down quiet for the first cycles after reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            iei_meta <= 1'b0;
            iei_sync <= 1'b0;
        end else begin
            iei_meta <= chain_enable_in;
            iei_sync <= iei_meta;
        end
    end

    // Previous synchronised strobes, for edge detection
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            io_request_n_prev <= 1'b1;
            fetch_prev <= 1'b1;
        end else begin
            io_request_n_prev <= bus_sync.io_request_n;
            fetch_prev <= bus_sync.opcode_fetch_n;
        end
    end

    logic fetching;
    logic ack_cycle;
    logic ack_start;
    logic fetch_read;
    logic fetch_end;

    assign fetching = !bus_sync.opcode_fetch_n;
    // Acknowledge is fetch plus I/O request together
    assign ack_cycle = fetching && !bus_sync.io_request_n;
    assign ack_start = ack_cycle && io_request_n_prev;
    assign fetch_end = !fetch_prev && !fetching;
    // Opcode byte is taken as the fetch strobe rises. Both strobes rise together
    // at the end of an acknowledge, so the I/O strobe must have been high before
    // as well, or the acknowledge would be decoded as an opcode.
    assign fetch_read = fetch_end && io_request_n_prev && bus_sync.io_request_n;

    // ------------------------------------------------------------
    // Pending state
    // ------------------------------------------------------------
    dci_lvl_t pending;
    dci_lvl_t served_sel;
    dci_lvl_t next_pending;

    // A source must drop its request once served; one still high when its
    // latch clears is taken as a new request
    // Sources sampled only outside a fetch so the chain stays put
    always_comb begin
        next_pending = pending;
        if (!fetching) begin
            next_pending = source_req & ~in_service;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // ------------------------------------------------------------
    // Return opcode decoder
    // ------------------------------------------------------------
    dci_dec_e dec_state;
    logic prefix_seen;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dec_state <= DCI_IDLE;
        end else if (fetch_read) begin
            case (dec_state)
                DCI_IDLE: begin
                    if (bus_sync.data == `DCI_OP_PREFIX) begin
                        dec_state <= DCI_PREFIX_SEEN;
                    end
                end
                DCI_PREFIX_SEEN: begin
                    if (bus_sync.data == `DCI_OP_PREFIX) begin
                        dec_state <= DCI_PREFIX_SEEN;
                    end else begin
                        dec_state <= DCI_IDLE;
                    end
                end
                default: begin
                    dec_state <= DCI_IDLE;
                end
            endcase
        end
    end

    // A repeated prefix keeps the decoder armed; any other byte disarms it
    assign prefix_seen = (dec_state == DCI_PREFIX_SEEN);

    // ------------------------------------------------------------
    // Internal chain: each level blocks those below it
    // ------------------------------------------------------------
    dci_lvl_t blockers;
    dci_lvl_t ack_sel;
    logic chain_busy;

    always_comb begin
        // After the prefix, unacknowledged levels stop blocking
        blockers = prefix_seen ? in_service : (pending | in_service);
        // Nesting: only a pending level above every in-service one wins
        ack_sel = dci_top(pending | in_service) & pending;
        served_sel = dci_top(in_service);
        chain_busy = |blockers;
    end

    // ------------------------------------------------------------
    // Request visibility
    // ------------------------------------------------------------
    dci_lvl_t shadowed;
    dci_lvl_t visible;

    // A level below the top in-service one waits until that service ends,
    // so the processor is not pulled away for a request it cannot take yet
    always_comb begin
        shadowed = dci_below(dci_top(in_service)) | in_service;
        visible = pending & ~shadowed;
    end

    // ------------------------------------------------------------
    // Acknowledge and return events
    // ------------------------------------------------------------
    logic ack_grant;
    logic return_match;
    logic opcode_clear;
    logic command_clear;

    // Only the device whose chain input is high may answer
    assign ack_grant = ack_start && iei_sync && |ack_sel;
    assign return_match = fetch_read && prefix_seen && bus_sync.data == `DCI_OP_RETURN;
    // Chain input high and output low marks the device being served
    assign opcode_clear = return_match && iei_sync && |in_service;
    assign command_clear = return_cmd && |in_service;

    // ------------------------------------------------------------
    // In-service latches
    // ------------------------------------------------------------
    // An acknowledge outranks a clear in the same cycle: a command pulse
    // that meets an acknowledge is dropped, so it must not be issued then
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            in_service <= '0;
        end else begin
            if (ack_grant) begin
                in_service <= in_service | ack_sel;
            end else if (opcode_clear) begin
                in_service <= in_service & ~served_sel;
            end else if (command_clear) begin
                in_service <= in_service & ~served_sel;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            int_req_n <= 1'b1;
        end else begin
            int_req_n <= !(|visible);
        end
    end

    // Chain input passes one flop behind its synchroniser
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chain_enable_out <= 1'b0;
        end else begin
            chain_enable_out <= iei_sync && !chain_busy;
        end
    end

    // Vector is loaded once per acknowledge and left in place afterwards;
    // only the drive enable tells the bus whether it is valid
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            data_out <= '0;
        end else if (ack_grant) begin
            data_out <= dci_vector(vector_base, ack_sel);
        end
    end

    // Drive holds for the whole acknowledge; dropped when either strobe rises
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            data_oe <= 1'b0;
        end else if (ack_grant) begin
            data_oe <= 1'b1;
        end else if (!ack_cycle || fetch_end) begin
            data_oe <= 1'b0;
        end
    end

    // Read strobe is synchronised with the rest of the bus but not needed:
    // fetch and acknowledge are told apart by the two other strobes
    logic unused_read;
    assign unused_read = bus_sync.read_n;

endmodule : dci_daisy_chain

// ===== sim/dci_daisy_chain_assertions.sv
// Port-level checks for the daisy-chain interrupt logic.
// Assumes the bind below and a two-flop sync on every pin input of the design.
`timescale 1ns/100ps
module dci_daisy_chain_assertions (
    input wire logic mclk,
    input wire logic rst_b,
    input wire dci_pkg::dci_bus_s bus_pin,
    input wire logic chain_enable_in,
    input wire dci_pkg::dci_lvl_t source_req,
    input wire logic return_cmd,
    input wire logic int_req_n,
    input wire logic chain_enable_out,
    input wire logic data_oe,
    input wire dci_pkg::dci_lvl_t in_service
);
    import dci_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence quiet;
        (source_req == 0 && bus_pin.opcode_fetch_n)[*5];
    endsequence
    sequence bus_idle;
        (bus_pin.opcode_fetch_n && bus_pin.io_request_n)[*4];
    endsequence
    sequence ack_start;
        $fell(bus_pin.io_request_n) && !bus_pin.opcode_fetch_n && chain_enable_in && !int_req_n;
    endsequence
    property p_reset;
        disable iff (1'b0) (!rst_b)[*2] |->
            int_req_n && !data_oe && in_service == 0 && !chain_enable_out;
    endproperty
    a_req_idle: assert property (quiet |=> int_req_n) else $error("request without source");
    a_chain_pass: assert property ((chain_enable_in && in_service == 0 && source_req == 0
        && bus_pin.opcode_fetch_n)[*5] |=> chain_enable_out) else $error("chain not passed");
    a_chain_low: assert property ((!chain_enable_in)[*3] |=> !chain_enable_out)
        else $error("chain out high with input low");
    a_chain_busy: assert property ((in_service != 0)[*2] |-> !chain_enable_out)
        else $error("chain not blocked in service");
    a_ack_vector: assert property (ack_start |-> ##3 data_oe) else $error("no vector");
    a_one_level: assert property ($rose(data_oe)
        |-> $countones(in_service ^ $past(in_service)) == 1)
        else $error("ack changed other than one level");
    a_oe_drop: assert property ($rose(bus_pin.io_request_n) && data_oe |-> ##3 !data_oe)
        else $error("vector drive held");
    a_cmd_clear: assert property (bus_idle ##0 return_cmd && in_service != 0 |=>
        in_service == ($past(in_service) & ($past(in_service) - 6'h01)))
        else $error("return command wrong clear");
    a_reset_state: assert property (p_reset) else $error("reset state wrong");
endmodule : dci_daisy_chain_assertions

bind dci_daisy_chain dci_daisy_chain_assertions u_dci_daisy_chain_assertions (.mclk(mclk),
    .rst_b(rst_b), .bus_pin(bus_pin), .chain_enable_in(chain_enable_in),
    .source_req(source_req), .return_cmd(return_cmd), .int_req_n(int_req_n),
    .chain_enable_out(chain_enable_out), .data_oe(data_oe), .in_service(in_service));

// ===== sim/dci_cpu_model.sv
// Processor bus model: fetch and acknowledge cycles on the strobes.
// Assumes the caller waits for the request; drives at falling edges.
`timescale 1ns/100ps
module dci_cpu_model (
    input wire logic mclk,
    output dci_pkg::dci_bus_s bus
);
    import dci_pkg::*;
    initial bus = '{1'b1, 1'b1, 1'b1, 8'h00};
    // Io low gives acknowledge, high gives an opcode fetch
    task automatic cycle(input logic io_request_n_n, input dci_byte_t d);
        @(negedge mclk);
        bus.data = d;
        bus.opcode_fetch_n = 1'b0;
        bus.io_request_n = io_request_n_n;
        repeat (4) @(negedge mclk);
        bus.opcode_fetch_n = 1'b1;
        bus.io_request_n = 1'b1;
        @(negedge mclk);
        // Released bus shows a flipped value, not the stale byte
        bus.data = ~d;
        repeat (4) @(negedge mclk);
    endtask : cycle
endmodule : dci_cpu_model

// ===== sim/daisy_chain_interrupt_logic_tb_top.sv
// Self-checking bench: level service, nesting, return opcodes, refusal.
// Assumes the cpu model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t mismatch", $time); end end
module daisy_chain_interrupt_logic_tb_top;
    import dci_pkg::*;
    logic mclk = 0, rst_b = 0, chain_enable_in = 1, return_cmd = 0, oe_q = 0;
    logic int_req_n, chain_enable_out, data_oe;
    dci_bus_s bus_pin;
    dci_lvl_t source_req = '0, in_service;
    dci_byte_t vector_base = 8'h00, data_out;
    dci_byte_t expq[$];
    int fails = 0, n_checks = 0;
    logic [31:0] rng = 32'h0000_0041;
    always #20 mclk = ~mclk;
    dci_daisy_chain u_dci_daisy_chain (.mclk(mclk), .rst_b(rst_b), .bus_pin(bus_pin),
        .chain_enable_in(chain_enable_in), .source_req(source_req), .return_cmd(return_cmd),
        .vector_base(vector_base), .int_req_n(int_req_n), .chain_enable_out(chain_enable_out),
        .data_out(data_out), .data_oe(data_oe), .in_service(in_service));
    dci_cpu_model u_dci_cpu_model (.mclk(mclk), .bus(bus_pin));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    task automatic close_out;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic settle(input int n);
        repeat (n) @(negedge mclk);
    endtask : settle
    task automatic serve(input int lvl);
        int i;
        source_req[lvl] = 1'b1;
        for (i = 0; i < 50 && int_req_n !== 1'b0; i++) @(negedge mclk);
        if (i == 50) begin
            fails++;
            close_out();
        end
        expq.push_back(vector_base | 8'(lvl << 1));
        u_dci_cpu_model.cycle(1'b0, 8'h00);
        source_req[lvl] = 1'b0;
    endtask : serve
    // Every vector drive must match the oldest expected vector
    always @(posedge mclk) begin
        oe_q <= data_oe;
        if (data_oe === 1'b1 && oe_q !== 1'b1) begin
            if (expq.size() == 0) begin
                fails++;
                $display("BAD %0t unexpected vector", $time);
            end
            else `CHK(data_out, expq.pop_front())
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        settle(4);
        rst_b = 1'b1;
        settle(4);
        `CHK(chain_enable_out, 1'b1)
        `CHK(int_req_n, 1'b1)
        for (int l = 0; l < 6; l++) begin
            rng = xs(rng);
            vector_base = rng[7:0] & 8'hf1;
            serve(l);
            settle(2);
            `CHK(in_service, dci_lvl_t'(1 << l))
            `CHK(chain_enable_out, 1'b0)
            return_cmd = 1'b1;
            settle(1);
            return_cmd = 1'b0;
            settle(1);
            `CHK(in_service, dci_lvl_t'(0))
        end
        $display("test levels done");
        serve(5);
        serve(0);
        `CHK(in_service, 6'h21)
        u_dci_cpu_model.cycle(1'b1, 8'hed);
        u_dci_cpu_model.cycle(1'b1, 8'h4d);
        `CHK(in_service, 6'h20)
        u_dci_cpu_model.cycle(1'b1, 8'hed);
        u_dci_cpu_model.cycle(1'b1, 8'h4d);
        `CHK(in_service, 6'h00)
        $display("test nesting done");
        source_req[2] = 1'b1;
        u_dci_cpu_model.cycle(1'b1, 8'hed);
        `CHK(chain_enable_out, 1'b1)
        u_dci_cpu_model.cycle(1'b1, 8'h00);
        `CHK(chain_enable_out, 1'b0)
        source_req[2] = 1'b0;
        $display("test prefix done");
        chain_enable_in = 1'b0;
        source_req[1] = 1'b1;
        settle(4);
        `CHK(int_req_n, 1'b0)
        u_dci_cpu_model.cycle(1'b0, 8'h00);
        `CHK(in_service, 6'h00)
        `CHK(chain_enable_out, 1'b0)
        source_req[1] = 1'b0;
        chain_enable_in = 1'b1;
        settle(8);
        `CHK(chain_enable_out, 1'b1)
        $display("test refusal done");
        serve(4);
        serve(2);
        `CHK(in_service, 6'h14)
        return_cmd = 1'b1;
        settle(1);
        return_cmd = 1'b0;
        settle(1);
        `CHK(in_service, 6'h10)
        source_req[3] = 1'b1;
        settle(4);
        `CHK(int_req_n, 1'b0)
        rst_b = 1'b0;
        settle(2);
        rst_b = 1'b1;
        `CHK(in_service, 6'h00)
        `CHK(int_req_n, 1'b1)
        `CHK(chain_enable_out, 1'b0)
        source_req[3] = 1'b0;
        settle(4);
        `CHK(chain_enable_out, 1'b1)
        `CHK(expq.size(), 0)
        $display("test reset done");
        close_out();
    end
endmodule : daisy_chain_interrupt_logic_tb_top
